// *** bdm_pkg.sv ***
// constants and types shared by the banked data memory addressing block
// What this block does
// [RQ1] data addresses are twelve bits, 4096 bytes
// [RQ2] sixteen banks of 256 bytes, bank high
// [RQ3] all sixteen banks present by default
// [RQ4] unimplemented locations read back as zero
// [RQ5] full address or bank plus offset
// [RQ6] bank pointer high nibble, operand low byte
// [RQ7] bank pointer bits 7:4 read zero
// [RQ8] load bank literal writes bank pointer
// [RQ9] absent bank: write dropped, read zero
// [RQ10] flag update happens even for absent banks
// [RQ11] full move uses both twelve-bit addresses
// [RQ12] access map: bank 0 low, bank 15 high
// [RQ13] select bit 1 banked, 0 access map
// [RQ14] access map needs no bank pointer update
// [RQ15] bank 15 offset F9h writes program counter
// [RQ16] general RAM from 000h, never reset
// [RQ17] operand read Q2, destination write Q4
// [RQ18] special registers occupy F40h up to FFFh
// [RQ19] access map nibble 0h below 60h, else Fh
package bdm_pkg;

	// =====================================================================
	// address geometry
	localparam int ADDR_WIDTH = 12;
	localparam int OFFSET_WIDTH = 8;
	localparam int BANK_WIDTH = 4;
	localparam int NUM_BANKS = 16;
	localparam int BANK_BYTES = 256;
	localparam int MEM_BYTES = 4096;
	localparam int DATA_WIDTH = 8;

	// =====================================================================
	// access bank map
	localparam logic [7:0] ACCESS_SPLIT = 8'h60;
	localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
	localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;

	// =====================================================================
	// fixed locations and regions
	localparam logic [11:0] GPR_BASE = 12'h000;
	localparam logic [11:0] GPR_LIMIT_DEFAULT = 12'hec0;
	localparam logic [11:0] SFR_BASE = 12'hf40;
	localparam logic [11:0] SFR_TOP = 12'hfff;
	localparam logic [11:0] BANK_POINTER_ADDR = 12'hfe0;
	localparam logic [11:0] PC_LOW_ADDR = 12'hff9;

	// =====================================================================
	// bank pointer layout and reset
	localparam logic [3:0] BANK_POINTER_RESET = 4'h0;
	localparam logic [3:0] BANK_POINTER_UPPER_READ = 4'h0;
	localparam logic [15:0] BANK_PRESENT_DEFAULT = 16'hffff;

	// =====================================================================
	// instruction cycle phases, one core clock each
	typedef enum logic [1:0]
	{
		PHASE_Q1 = 2'b00,
		PHASE_Q2 = 2'b01,
		PHASE_Q3 = 2'b10,
		PHASE_Q4 = 2'b11
	} bdm_phase_type;

	// data memory operation classes issued by the pipeline
	typedef enum logic [1:0]
	{
		OP_NONE = 2'b00,
		OP_FILE = 2'b01,
		OP_LOAD_BANK = 2'b10,
		OP_FULL_MOVE = 2'b11
	} bdm_op_type;

endpackage

// *** bdm_memory.sv ***
// banked data memory: address generation, general RAM and bank pointer
`timescale 1ns/100ps
module bdm_memory
#(
	parameter logic [11:0] GPR_LIMIT = bdm_pkg::GPR_LIMIT_DEFAULT,
	parameter logic [15:0] BANK_PRESENT = bdm_pkg::BANK_PRESENT_DEFAULT
)
(
	input wire logic core_clk,
	input wire logic rst,
	output bdm_pkg::bdm_phase_type phase,
	input wire logic instr_valid,
	input wire bdm_pkg::bdm_op_type instr_op,
	input wire logic instr_access_select,
	input wire logic [7:0] instr_offset,
	input wire logic [7:0] instr_literal,
	input wire logic [11:0] instr_src_addr,
	input wire logic [11:0] instr_dst_addr,
	input wire logic instr_writes_file,
	input wire logic instr_updates_flags,
	input wire logic [7:0] result_data,
	output logic [7:0] operand_data,
	output logic operand_valid,
	output logic status_update,
	output logic [7:0] bank_pointer,
	output logic program_counter_low_byte_write,
	output logic [7:0] program_counter_low_byte,
	output logic sfr_read,
	output logic sfr_write,
	output logic [11:0] sfr_addr,
	output logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	input wire logic sfr_present
);
	import bdm_pkg::*;

	// =====================================================================
	// helper functions

	// banked or access-map address from an eight-bit operand
	function automatic logic [11:0] effective_addr(input logic banked, input logic [3:0] bank,
		input logic [7:0] offset);
		logic [3:0] upper;
		upper = bank;
		if (!banked)
		begin
			upper = (offset < ACCESS_SPLIT) ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK; // [RQ12] [RQ19]
		end
		return {upper, offset}; // [RQ2] [RQ6]
	endfunction

	function automatic logic in_gpr(input logic [11:0] addr);
		return (addr >= GPR_BASE) && (addr < GPR_LIMIT); // [RQ16]
	endfunction

	function automatic logic in_sfr(input logic [11:0] addr);
		return (addr >= SFR_BASE) && (addr <= SFR_TOP); // [RQ18]
	endfunction

	function automatic logic bank_ok(input logic [11:0] addr);
		return BANK_PRESENT[addr[11:8]]; // [RQ3] [RQ9]
	endfunction

	// =====================================================================
	// state

	bdm_phase_type next_phase;
	logic [3:0] bank_bits;
	logic cur_valid;
	bdm_op_type cur_op;
	logic cur_access_select;
	logic [7:0] cur_offset;
	logic [7:0] cur_literal;
	logic [11:0] cur_src_addr;
	logic [11:0] cur_dst_addr;
	logic cur_writes_file;
	logic cur_updates_flags;
	// storage only: no reset, so contents survive every reset
	logic [7:0] gpr_mem [0:MEM_BYTES-1];

	// =====================================================================
	// phase divider: one instruction cycle is four core clocks

	always_comb
	begin
		unique case (phase)
			PHASE_Q1: next_phase = PHASE_Q2;
			PHASE_Q2: next_phase = PHASE_Q3;
			PHASE_Q3: next_phase = PHASE_Q4;
			PHASE_Q4: next_phase = PHASE_Q1;
		endcase
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			phase <= PHASE_Q1;
		end
		else
		begin
			phase <= next_phase;
		end
	end

	wire logic at_q1 = (phase == PHASE_Q1);
	wire logic at_q2 = (phase == PHASE_Q2); // [RQ17]
	wire logic at_q4 = (phase == PHASE_Q4); // [RQ17]

	// =====================================================================
	// instruction capture at Q1

	// one short block per field, so each register shows its own reset and enable
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			cur_valid <= 1'b0;
		end
		else if (at_q1)
		begin
			cur_valid <= instr_valid;
		end
	end

	// an empty slot decodes as no operation, whatever the op field holds
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			cur_op <= OP_NONE;
		end
		else if (at_q1)
		begin
			cur_op <= instr_valid ? instr_op : OP_NONE;
		end
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			cur_access_select <= 1'b0;
		end
		else if (at_q1)
		begin
			cur_access_select <= instr_access_select;
		end
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			cur_offset <= 8'h00;
		end
		else if (at_q1)
		begin
			cur_offset <= instr_offset;
		end
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			cur_literal <= 8'h00;
		end
		else if (at_q1)
		begin
			cur_literal <= instr_literal;
		end
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			cur_src_addr <= 12'h000;
		end
		else if (at_q1)
		begin
			cur_src_addr <= instr_src_addr;
		end
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			cur_dst_addr <= 12'h000;
		end
		else if (at_q1)
		begin
			cur_dst_addr <= instr_dst_addr;
		end
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			cur_writes_file <= 1'b0;
		end
		else if (at_q1)
		begin
			cur_writes_file <= instr_valid && instr_writes_file;
		end
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			cur_updates_flags <= 1'b0;
		end
		else if (at_q1)
		begin
			cur_updates_flags <= instr_valid && instr_updates_flags;
		end
	end

	// =====================================================================
	// address generation

	// the access map path ignores bank_bits, so no pointer update precedes it
	wire logic [11:0] file_addr = effective_addr(cur_access_select, bank_bits, cur_offset); // [RQ13] [RQ14]
	wire logic is_full_move = (cur_op == OP_FULL_MOVE);
	// full move never looks at the bank pointer
	wire logic [11:0] read_addr = is_full_move ? cur_src_addr : file_addr; // [RQ11] [RQ5]
	wire logic [11:0] write_addr = is_full_move ? cur_dst_addr : file_addr; // [RQ11] [RQ1]

	// =====================================================================
	// read decode, used in Q2

	wire logic read_active = cur_valid && at_q2 && ((cur_op == OP_FILE) || is_full_move);
	wire logic read_bank_ok = bank_ok(read_addr);
	wire logic read_gpr = read_bank_ok && in_gpr(read_addr);
	wire logic read_bp = read_bank_ok && (read_addr == BANK_POINTER_ADDR);
	wire logic read_sfr = read_bank_ok && in_sfr(read_addr) && !read_bp;
	wire logic [7:0] read_value =
		read_gpr ? gpr_mem[read_addr] :
		read_bp ? bank_pointer :
		(read_sfr && sfr_present) ? sfr_rdata :
		8'h00; // [RQ4] [RQ9]

	// =====================================================================
	// write decode, used in Q4

	wire logic file_write = cur_valid && at_q4 && cur_writes_file && (cur_op == OP_FILE);
	wire logic move_write = cur_valid && at_q4 && is_full_move;
	wire logic write_active = file_write || move_write;
	// a full move carries the byte it read in Q2
	wire logic [7:0] write_value = is_full_move ? operand_data : result_data;
	wire logic write_bank_ok = bank_ok(write_addr);
	wire logic write_gpr = write_active && write_bank_ok && in_gpr(write_addr); // [RQ9]
	wire logic write_bp = write_active && write_bank_ok && (write_addr == BANK_POINTER_ADDR);
	wire logic write_pc_low = write_active && write_bank_ok && (write_addr == PC_LOW_ADDR); // [RQ15]
	wire logic write_sfr = write_active && write_bank_ok && in_sfr(write_addr) && !write_bp && !write_pc_low;
	wire logic load_bank = cur_valid && at_q4 && (cur_op == OP_LOAD_BANK);

	// =====================================================================
	// special register port: read address in Q2, write address in Q4

	assign sfr_read = read_active && read_sfr;
	assign sfr_write = write_sfr;
	assign sfr_addr = at_q4 ? write_addr : read_addr;
	assign sfr_wdata = write_value;

	// =====================================================================
	// general RAM, no reset on purpose

	always_ff @(posedge core_clk)
	begin
		if (write_gpr)
		begin
			gpr_mem[write_addr] <= write_value; // [RQ16]
		end
	end

	// =====================================================================
	// bank pointer: only the low nibble is storage

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			bank_bits <= BANK_POINTER_RESET;
		end
		else if (load_bank)
		begin
			bank_bits <= cur_literal[3:0]; // [RQ8] [RQ7]
		end
		else if (write_bp)
		begin
			bank_bits <= write_value[3:0]; // [RQ7]
		end
	end

	assign bank_pointer = {BANK_POINTER_UPPER_READ, bank_bits}; // [RQ7]

	// =====================================================================
	// operand register and Q4 strobes

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			operand_data <= 8'h00;
			operand_valid <= 1'b0;
		end
		else
		begin
			operand_valid <= read_active; // [RQ17]
			if (read_active)
			begin
				operand_data <= read_value; // [RQ4]
			end
		end
	end

	// flags follow the instruction, never whether the target bank exists
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			status_update <= 1'b0;
		end
		else
		begin
			status_update <= cur_valid && at_q4 && cur_updates_flags; // [RQ10]
		end
	end

	// the program counter lives elsewhere: this block only forwards the byte
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			program_counter_low_byte_write <= 1'b0;
		end
		else
		begin
			program_counter_low_byte_write <= write_pc_low; // [RQ15]
		end
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			program_counter_low_byte <= 8'h00;
		end
		else if (write_pc_low)
		begin
			program_counter_low_byte <= write_value; // [RQ15]
		end
	end

endmodule

// *** bdm_memory_props.sv ***
// concurrent checks on the banked data memory ports
`timescale 1ns/100ps
module bdm_memory_props
(
	input wire logic core_clk,
	input wire logic rst,
	input wire bdm_pkg::bdm_phase_type phase,
	input wire logic instr_valid,
	input wire bdm_pkg::bdm_op_type instr_op,
	input wire logic instr_access_select,
	input wire logic [7:0] instr_offset,
	input wire logic [7:0] instr_literal,
	input wire logic instr_updates_flags,
	input wire logic operand_valid,
	input wire logic status_update,
	input wire logic [7:0] bank_pointer,
	input wire logic program_counter_low_byte_write,
	input wire logic sfr_read,
	input wire logic sfr_write,
	input wire logic [11:0] sfr_addr
);
	import bdm_pkg::*;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	wire take = phase == PHASE_Q1 && instr_valid;
	wire file_take = take && instr_op == OP_FILE;
	// =====================================================================
	// assertions
	a_phase_wrap: assert property (phase == PHASE_Q4 |=> phase == PHASE_Q1)
		else $error("phase did not wrap to Q1");
	a_valid_q3: assert property (operand_valid |-> phase == PHASE_Q3)
		else $error("operand valid outside Q3");
	a_upper_zero: assert property (bank_pointer[7:4] == 4'h0)
		else $error("bank pointer upper bits set");
	a_load_nibble: assert property (take && instr_op == OP_LOAD_BANK
		|-> ##4 bank_pointer == {4'h0, $past(instr_literal[3:0], 4)})
		else $error("bank load not applied");
	a_flag_pulse: assert property (file_take && instr_updates_flags |-> ##4 status_update)
		else $error("flag update missing");
	a_status_q1: assert property (status_update |-> phase == PHASE_Q1)
		else $error("flag update in wrong phase");
	a_sfr_rd_q2: assert property (sfr_read |-> phase == PHASE_Q2 && sfr_addr >= SFR_BASE)
		else $error("special register read misplaced");
	a_sfr_wr_q4: assert property (sfr_write |-> phase == PHASE_Q4 && sfr_addr >= SFR_BASE
		&& sfr_addr != PC_LOW_ADDR)
		else $error("special register write misplaced");
	a_banked_addr: assert property (file_take && instr_access_select && bank_pointer[3:0] == 4'hf
		&& instr_offset >= 8'h40 && instr_offset != 8'he0
		|=> sfr_read && sfr_addr == {$past(bank_pointer[3:0]), $past(instr_offset)})
		else $error("banked address wrong");
	a_access_map: assert property (file_take && !instr_access_select && instr_offset >= 8'h60
		&& instr_offset != 8'he0 |=> sfr_read && sfr_addr == {4'hf, $past(instr_offset)})
		else $error("access map address wrong");
	a_pc_low_single: assert property (program_counter_low_byte_write |=> !program_counter_low_byte_write)
		else $error("program counter write too long");
	c_load: cover property (take && instr_op == OP_LOAD_BANK);
	c_move: cover property (take && instr_op == OP_FULL_MOVE);
	c_pc_low: cover property (program_counter_low_byte_write);
	c_sfr_write: cover property (sfr_write);
endmodule

bind bdm_memory bdm_memory_props i_props (.core_clk, .rst, .phase, .instr_valid, .instr_op, .instr_access_select,
	.instr_offset, .instr_literal, .instr_updates_flags, .operand_valid, .status_update, .bank_pointer,
	.program_counter_low_byte_write, .sfr_read, .sfr_write, .sfr_addr);

// *** bdm_sfr_model.sv ***
// special function register responder standing at the far side
`timescale 1ns/100ps
module bdm_sfr_model
(
	input wire logic core_clk,
	input wire logic sfr_read,
	input wire logic [11:0] sfr_addr,
	output logic [7:0] sfr_rdata,
	output logic sfr_present
);
	logic [7:0] last = 8'h00;
	wire [7:0] value = sfr_addr[7:0] ^ 8'h5a;
	// one hole so an absent register must read zero
	assign sfr_present = sfr_addr != 12'hfd4;
	// the inverted last read byte outside a read
	assign sfr_rdata = sfr_read ? value : ~last;
	always_ff @(posedge core_clk)
	begin
		if (sfr_read)
			last <= value;
	end
endmodule

// *** testbench.sv ***
// self-checking bench for the banked data memory block
`timescale 1ns/100ps
module testbench;
	import bdm_pkg::*;
	// f holds pc low write, check, flags, write from bit 3 down
	typedef struct packed {bdm_op_type op; logic a; logic [7:0] off; logic [23:0] mv; logic [3:0] f;
		logic [7:0] res; logic [7:0] exp; logic [7:0] bp;} bdm_row_type;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic instr_valid = 1'b0;
	bdm_op_type instr_op = OP_NONE;
	logic instr_access_select = 1'b0;
	logic [7:0] instr_offset = 8'h00;
	logic [11:0] instr_src_addr = 12'h000;
	logic [11:0] instr_dst_addr = 12'h000;
	logic instr_writes_file = 1'b0;
	logic instr_updates_flags = 1'b0;
	logic [7:0] result_data = 8'h00;
	bdm_phase_type phase;
	logic [7:0] operand_data, bank_pointer, program_counter_low_byte, sfr_rdata, sfr_wdata;
	logic operand_valid, status_update, program_counter_low_byte_write, sfr_read, sfr_write, sfr_present;
	logic [11:0] sfr_addr;
	int num_errors = 0;
	int total_checks = 0;
	logic prev_fl = 1'b0;
	logic prev_pc_low = 1'b0;
	logic exp_sfr_wr = 1'b0;
	bdm_row_type rows[19];
	// bank 7 left out to see dropped writes
	bdm_memory #(.BANK_PRESENT(16'hff7f)) i_dut (.core_clk, .rst, .phase, .instr_valid, .instr_op, .instr_access_select,
		.instr_offset, .instr_literal(instr_offset), .instr_src_addr, .instr_dst_addr, .instr_writes_file,
		.instr_updates_flags, .result_data, .operand_data, .operand_valid, .status_update, .bank_pointer,
		.program_counter_low_byte_write, .program_counter_low_byte, .sfr_read, .sfr_write, .sfr_addr, .sfr_wdata,
		.sfr_rdata, .sfr_present);
	bdm_sfr_model i_sfr (.core_clk, .sfr_read, .sfr_addr, .sfr_rdata, .sfr_present);
	initial
	begin
		forever #2.5 core_clk = ~core_clk;
	end
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// =====================================================================
	// one instruction, issued so that back to back calls fill every cycle
	task automatic exec(input bdm_row_type r);
		int n;
		n = 0;
		while (phase !== PHASE_Q4)
		begin
			@(negedge core_clk);
			n++;
			if (n > 8)
			begin
				num_errors++;
				results();
			end
		end
		@(posedge core_clk);
		instr_valid <= r.op != OP_NONE;
		instr_op <= r.op;
		instr_access_select <= r.a;
		instr_offset <= r.off;
		instr_src_addr <= r.mv[23:12];
		instr_dst_addr <= r.mv[11:0];
		instr_writes_file <= r.f[0];
		instr_updates_flags <= r.f[1];
		result_data <= r.res;
		@(negedge core_clk);
		check("status_update", 8'(status_update), 8'(prev_fl));
		check("pc_low_write", 8'(program_counter_low_byte_write), 8'(prev_pc_low));
		if (prev_pc_low)
			check("pc_low_data", program_counter_low_byte, 8'h42);
		repeat (2) @(negedge core_clk);
		if (r.f[2])
		begin
			check("operand_valid", 8'(operand_valid), 8'h01);
			check("operand_data", operand_data, r.exp);
		end
		check("bank_pointer", bank_pointer, r.bp);
		prev_fl = r.f[1] && r.op == OP_FILE;
		prev_pc_low = r.f[3];
		// the last negedge falls in Q4, where the special register write strobe stands
		@(negedge core_clk);
		check("sfr_write", 8'(sfr_write), 8'(exp_sfr_wr));
		if (exp_sfr_wr)
		begin
			check("sfr_wdata", sfr_wdata, r.res);
			check("sfr_addr", sfr_addr[7:0], r.off);
		end
	endtask
	initial
	begin
		rows = '{'{OP_LOAD_BANK, 1'b0, 8'hf3, 24'h0, 4'h0, 8'h00, 8'h00, 8'h00},
			'{OP_FILE, 1'b1, 8'h10, 24'h0, 4'h3, 8'ha5, 8'h00, 8'h03},
			'{OP_FILE, 1'b1, 8'h10, 24'h0, 4'h4, 8'h00, 8'ha5, 8'h03},
			'{OP_FILE, 1'b0, 8'h10, 24'h0, 4'h1, 8'h3c, 8'h00, 8'h03},
			'{OP_FULL_MOVE, 1'b0, 8'h00, 24'h010311, 4'h4, 8'h00, 8'h3c, 8'h03},
			'{OP_FILE, 1'b1, 8'h11, 24'h0, 4'h4, 8'h00, 8'h3c, 8'h03},
			'{OP_FILE, 1'b0, 8'he0, 24'h0, 4'h4, 8'h00, 8'h03, 8'h03},
			'{OP_FULL_MOVE, 1'b0, 8'h00, 24'h010fe0, 4'h4, 8'h00, 8'h3c, 8'h03},
			'{OP_LOAD_BANK, 1'b0, 8'h0f, 24'h0, 4'h0, 8'h00, 8'h00, 8'h0c},
			'{OP_FILE, 1'b1, 8'hf9, 24'h0, 4'hd, 8'h42, 8'ha3, 8'h0f},
			'{OP_FILE, 1'b1, 8'hd4, 24'h0, 4'h4, 8'h00, 8'h00, 8'h0f},
			'{OP_LOAD_BANK, 1'b0, 8'h07, 24'h0, 4'h0, 8'h00, 8'h00, 8'h0f},
			'{OP_FILE, 1'b0, 8'h70, 24'h0, 4'h4, 8'h00, 8'h2a, 8'h07},
			'{OP_FILE, 1'b1, 8'h20, 24'h0, 4'h3, 8'h99, 8'h00, 8'h07},
			'{OP_FILE, 1'b1, 8'h20, 24'h0, 4'h4, 8'h00, 8'h00, 8'h07},
			'{OP_LOAD_BANK, 1'b0, 8'h0e, 24'h0, 4'h0, 8'h00, 8'h00, 8'h07},
			'{OP_FILE, 1'b1, 8'hc0, 24'h0, 4'h3, 8'h77, 8'h00, 8'h0e},
			'{OP_FILE, 1'b1, 8'hc0, 24'h0, 4'h4, 8'h00, 8'h00, 8'h0e},
			'{OP_NONE, 1'b0, 8'h00, 24'h0, 4'h0, 8'h00, 8'h00, 8'h0e}};
		repeat (3) @(posedge core_clk);
		check("bank_pointer", bank_pointer, 8'h00);
		rst <= 1'b0;
		foreach (rows[i])
		begin
			exec(rows[i]);
			$display("test row %0d done", i);
		end
		// a second reset must leave general RAM alone
		@(posedge core_clk);
		rst <= 1'b1;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		exec(bdm_row_type'{OP_LOAD_BANK, 1'b0, 8'h03, 24'h0, 4'h0, 8'h00, 8'h00, 8'h00});
		exec(bdm_row_type'{OP_FILE, 1'b1, 8'h10, 24'h0, 4'h4, 8'h00, 8'ha5, 8'h03});
		$display("reset retention test done");
		// an access map write into the special register range must reach the port in Q4
		exp_sfr_wr = 1'b1;
		exec(bdm_row_type'{OP_FILE, 1'b0, 8'h80, 24'h0, 4'h1, 8'h5e, 8'h00, 8'h03});
		exp_sfr_wr = 1'b0;
		exec(bdm_row_type'{OP_NONE, 1'b0, 8'h00, 24'h0, 4'h0, 8'h00, 8'h00, 8'h03});
		$display("special register write test done");
		results();
	end
endmodule
